// *** hdl/pdil_pkg.sv ***
/*
 * pdil_pkg: constants, states and carriers for the predriver input
 * control and lockout block.
 * Assumes a single 40 MHz clock; command bytes come already deframed.
 */
package pdil_pkg;

    // clock and timing, in nanoseconds, then derived cycle counts
    localparam int PDIL_CLK_NS = 25;
    localparam int PDIL_ENABLE_NS = 280;
    localparam int PDIL_RECOV_NS = 100;
    localparam int PDIL_ENABLE_CYC =
        (PDIL_ENABLE_NS + PDIL_CLK_NS - 1) / PDIL_CLK_NS;
    localparam int PDIL_RECOV_CYC =
        (PDIL_RECOV_NS + PDIL_CLK_NS - 1) / PDIL_CLK_NS;
    localparam int PDIL_CNT_W = 4;
    localparam logic [PDIL_CNT_W-1:0] PDIL_ENABLE_LAST =
        PDIL_CNT_W'(PDIL_ENABLE_CYC - 1);
    localparam logic [PDIL_CNT_W-1:0] PDIL_RECOV_LAST =
        PDIL_CNT_W'(PDIL_RECOV_CYC - 1);
    localparam logic [PDIL_CNT_W-1:0] PDIL_CNT_ZERO = 4'h0;
    localparam logic [PDIL_CNT_W-1:0] PDIL_CNT_ONE = 4'h1;

    // phases and interrupt sources
    localparam int PDIL_PHASES = 3;
    localparam int PDIL_IRQ_W = 8;

    // command byte: upper nibble selects the command
    localparam logic [3:0] PDIL_OP_POLL = 4'h0;
    localparam logic [3:0] PDIL_OP_MASK_LO = 4'h2;
    localparam logic [3:0] PDIL_OP_MASK_HI = 4'h3;
    localparam logic [3:0] PDIL_OP_MODE = 4'h4;
    localparam logic [3:0] PDIL_OP_CLEAR = 4'h6;
    // lower nibble of poll and clear commands
    localparam logic [3:0] PDIL_SEL_FIRST = 4'h0;
    localparam logic [3:0] PDIL_SEL_SECOND = 4'h1;
    // mode byte fields
    localparam int PDIL_LOCK_BIT = 0;
    localparam int PDIL_MODE_LSB = 1;
    localparam int PDIL_MODE_W = 3;

    // reset values
    localparam logic [PDIL_IRQ_W-1:0] PDIL_MASK_RST = 8'h00;
    localparam logic [PDIL_IRQ_W-1:0] PDIL_STATUS_RST = 8'h00;
    localparam logic [PDIL_MODE_W-1:0] PDIL_MODE_RST = 3'h0;
    localparam logic [7:0] PDIL_BYTE_RST = 8'h00;

    typedef enum logic [2:0] {
        PDIL_LOCKED = 3'b000,
        PDIL_ARMING = 3'b001,
        PDIL_ARMED = 3'b010,
        PDIL_CYCLING = 3'b011,
        PDIL_READY = 3'b100,
        PDIL_BLOCKED = 3'b101
    } pdil_stage_t;

    // phase inputs as driven by the host
    typedef struct packed {
        logic [PDIL_PHASES-1:0] low_cmd;
        logic [PDIL_PHASES-1:0] high_cmd_n;
    } pdil_phase_cmd_t;

    // gate drive outputs, active high = gate on
    typedef struct packed {
        logic [PDIL_PHASES-1:0] high_gate_out;
        logic [PDIL_PHASES-1:0] low_gate_out;
    } pdil_gate_t;

    // deframed command byte
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } pdil_cmd_t;

endpackage

// *** hdl/pdil_sync.sv ***
/*
 * pdil_sync: two-flop synchroniser with edge detection on the
 * synchronised value.
 * Assumes asynchronous pin inputs; reset is synchronous, active low.
 */
`timescale 1ns/1ps
module pdil_sync
    import pdil_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // pin side
    input wire logic [WIDTH-1:0] d,
    // synchronised side
    output logic [WIDTH-1:0] q,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] prev;

    // meta feeds only q
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
            prev <= '0;
        end else begin
            meta <= d;
            q <= meta;
            prev <= q;
        end
    end

    assign rise = q & ~prev;
    assign fall = ~q & prev;

endmodule

// *** hdl/pdil_top.sv ***
/*
 * pdil_top: input control and recovery logic of a three phase gate
 * predriver. Forces gates low on standby or fault, locks the high
 * sides and re-arms them on an ordered low then high toggle; also
 * holds the interrupt mask, sticky status, locked mode and the
 * one-frame-delayed command reply.
 * Assumes pins arrive unsynchronised; command bytes and fault events
 * come from logic on the same clock.
 */
// Operation
// - standby or fault shutdown drives every gate output low.
// - after shutdown high sides stay locked until a valid initialization.
// - low-side input held high for the recovery time while both enables high re-arms high side.
// - high-side edge before the low-side toggle keeps that gate locked out.
// - after high-side cycling the gate is left off, ready for control.
// - command nibbles 0010 and 0011 load the interrupt mask bits.
// - mode command with lock bit sets mode then blocks mode changes.
// - high-side inputs active low, low-side inputs active high.
// - command reply is returned in the following command frame.
`timescale 1ns/1ps
module pdil_top
    import pdil_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // enable and phase pins
    input wire logic enable_first,
    input wire logic enable_second,
    input wire pdil_phase_cmd_t phase_cmd,
    // protection side
    input wire logic fault_trip,
    input wire logic [PDIL_IRQ_W-1:0] fault_event,
    // deframed command and its delayed reply
    input wire pdil_cmd_t cmd,
    output logic [7:0] reply_byte,
    // gate drive
    output pdil_gate_t gate,
    // status
    output logic standby_state,
    output logic shutdown,
    output logic irq_out,
    output logic [PDIL_MODE_W-1:0] mode_bits,
    output logic mode_locked
);

    // pin synchronisation
    localparam int SYNC_W = 2 + 2 * PDIL_PHASES;
    logic [SYNC_W-1:0] pins_q, pins_rise, pins_fall;

    pdil_sync #(.WIDTH(SYNC_W)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .d({enable_second, enable_first, phase_cmd.low_cmd,
            phase_cmd.high_cmd_n}),
        .q(pins_q),
        .rise(pins_rise),
        .fall(pins_fall)
    );

    wire [PDIL_PHASES-1:0] hi_n = pins_q[PDIL_PHASES-1:0];
    wire [PDIL_PHASES-1:0] hi_rise = pins_rise[PDIL_PHASES-1:0];
    wire [PDIL_PHASES-1:0] hi_fall = pins_fall[PDIL_PHASES-1:0];
    wire [PDIL_PHASES-1:0] lo = pins_q[2*PDIL_PHASES-1:PDIL_PHASES];
    wire [PDIL_PHASES-1:0] lo_rise =
        pins_rise[2*PDIL_PHASES-1:PDIL_PHASES];
    wire both_en = pins_q[SYNC_W-1] & pins_q[SYNC_W-2];

    // standby exit: enables must stand for the exit time first
    logic [PDIL_CNT_W-1:0] en_cnt;
    logic normal;
    wire en_done = (en_cnt == PDIL_ENABLE_LAST);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            en_cnt <= PDIL_CNT_ZERO;
            normal <= 1'b0;
        end else if (!both_en) begin
            en_cnt <= PDIL_CNT_ZERO;
            normal <= 1'b0;
        end else begin
            en_cnt <= en_done ? en_cnt : en_cnt + PDIL_CNT_ONE;
            normal <= en_done;
        end
    end

    // command decode
    wire [3:0] op = cmd.data[7:4];
    wire [3:0] sel = cmd.data[3:0];
    wire do_mask_lo = cmd.valid && (op == PDIL_OP_MASK_LO);
    wire do_mask_hi = cmd.valid && (op == PDIL_OP_MASK_HI);
    wire do_mode = cmd.valid && (op == PDIL_OP_MODE) && !mode_locked;
    wire do_clr_first = cmd.valid && (op == PDIL_OP_CLEAR)
        && (sel == PDIL_SEL_FIRST);
    wire do_clr_second = cmd.valid && (op == PDIL_OP_CLEAR)
        && (sel == PDIL_SEL_SECOND);
    wire do_poll = cmd.valid && (op == PDIL_OP_POLL);

    // interrupt mask and sticky status
    logic [PDIL_IRQ_W-1:0] irq_mask, status;
    wire [PDIL_IRQ_W-1:0] clr_bits =
        {{4{do_clr_second}}, {4{do_clr_first}}};
    // a new event in the clearing cycle survives
    wire [PDIL_IRQ_W-1:0] next_status = (status & ~clr_bits) | fault_event;
    wire [PDIL_IRQ_W-1:0] next_mask = do_mask_hi ? {sel, irq_mask[3:0]}
        : do_mask_lo ? {irq_mask[7:4], sel} : irq_mask;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            status <= PDIL_STATUS_RST;
            irq_mask <= PDIL_MASK_RST;
            irq_out <= 1'b0;
        end else begin
            status <= next_status;
            irq_mask <= next_mask;
            irq_out <= |(next_status & ~next_mask);
        end
    end

    // mode register, lock is one way until reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mode_bits <= PDIL_MODE_RST;
            mode_locked <= 1'b0;
        end else if (do_mode) begin
            mode_bits <= cmd.data[PDIL_MODE_LSB +: PDIL_MODE_W];
            mode_locked <= cmd.data[PDIL_LOCK_BIT];
        end
    end

    // reply pipeline: answer is staged, shown on the next frame
    logic fault_latched;
    logic [7:0] pending;
    wire [7:0] answer =
        (do_poll && sel == PDIL_SEL_SECOND) ? status :
        (do_poll && sel != PDIL_SEL_FIRST) ?
            {3'h0, normal, mode_bits, mode_locked} :
        {2'h0, fault_latched, standby_state, status[3:0]};

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pending <= PDIL_BYTE_RST;
            reply_byte <= PDIL_BYTE_RST;
        end else if (cmd.valid) begin
            reply_byte <= pending;
            pending <= answer;
        end
    end

    // fault latch, held until a clear command with the trip gone
    wire any_clr = do_clr_first | do_clr_second;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fault_latched <= 1'b0;
        end else begin
            fault_latched <= fault_trip | (fault_latched & ~any_clr);
        end
    end

    wire shut = !normal || fault_latched || fault_trip;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            standby_state <= 1'b1;
            shutdown <= 1'b1;
        end else begin
            standby_state <= !normal;
            shutdown <= shut;
        end
    end

    // per phase gate requests; one register so gate has a single driver
    wire [PDIL_PHASES-1:0] next_hi_v;
    wire [PDIL_PHASES-1:0] next_lo_v;

    // per phase lockout and recovery
    genvar g;
    generate
        for (g = 0; g < PDIL_PHASES; g++) begin : g_phase
            pdil_stage_t stage, next_stage;
            logic [PDIL_CNT_W-1:0] held;
            wire hi_edge = hi_rise[g] | hi_fall[g];
            wire pulse_ok = (held == PDIL_RECOV_LAST);
            // high side may conduct only in cycling or ready
            wire hi_live = (stage == PDIL_CYCLING)
                || (stage == PDIL_READY);
            wire next_hi = !shut && hi_live && !hi_n[g];
            wire next_lo = !shut && lo[g] && !next_hi;

            assign next_hi_v[g] = next_hi;
            assign next_lo_v[g] = next_lo;

            always_comb begin
                next_stage = stage;
                case (stage)
                    PDIL_LOCKED: begin
                        if (hi_edge) begin
                            next_stage = PDIL_BLOCKED;
                        end else if (lo_rise[g]) begin
                            next_stage = PDIL_ARMING;
                        end
                    end
                    PDIL_ARMING: begin
                        if (hi_edge) begin
                            next_stage = PDIL_BLOCKED;
                        end else if (!lo[g]) begin
                            next_stage = PDIL_LOCKED;
                        end else if (pulse_ok) begin
                            next_stage = PDIL_ARMED;
                        end
                    end
                    PDIL_ARMED: begin
                        if (hi_fall[g]) begin
                            next_stage = PDIL_CYCLING;
                        end
                    end
                    PDIL_CYCLING: begin
                        if (hi_rise[g]) begin
                            next_stage = PDIL_READY;
                        end
                    end
                    default: next_stage = stage;
                endcase
                if (shut) begin
                    next_stage = PDIL_LOCKED;
                end
            end

            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    stage <= PDIL_LOCKED;
                    held <= PDIL_CNT_ZERO;
                end else begin
                    stage <= next_stage;
                    held <= (stage == PDIL_ARMING && !pulse_ok)
                        ? held + PDIL_CNT_ONE : PDIL_CNT_ZERO;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            gate <= '0;
        end else begin
            gate.high_gate_out <= next_hi_v;
            gate.low_gate_out <= next_lo_v;
        end
    end

endmodule

// *** dv/pdil_top_properties.sv ***
/*
 * pdil_top_properties: concurrent checks on the ports of pdil_top.
 * Assumes one clock domain and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module pdil_top_properties
    import pdil_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // pins and commands
    input wire logic enable_first,
    input wire logic enable_second,
    input wire pdil_phase_cmd_t phase_cmd,
    input wire logic fault_trip,
    input wire logic [PDIL_IRQ_W-1:0] fault_event,
    input wire pdil_cmd_t cmd,
    // outputs
    input wire logic [7:0] reply_byte,
    input wire pdil_gate_t gate,
    input wire logic standby_state,
    input wire logic shutdown,
    input wire logic irq_out,
    input wire logic [PDIL_MODE_W-1:0] mode_bits,
    input wire logic mode_locked
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence mode_cmd_s;
        cmd.valid && cmd.data[7:4] == PDIL_OP_MODE;
    endsequence
    shut_gates_a: assert property (shutdown [*2] |-> gate == '0)
        else $error("gates not low in shutdown");
    trip_shut_a: assert property (fault_trip |-> ##[1:3] shutdown)
        else $error("trip did not shut down");
    idle_standby_state_a: assert property (!enable_first [*5] |-> standby_state)
        else $error("enable low without standby");
    no_overlap_a: assert property (
        !(|(gate.high_gate_out & gate.low_gate_out)))
        else $error("high and low gate on together");
    mode_set_a: assert property (
        (!mode_locked ##0 mode_cmd_s) |=>
        mode_bits == $past(cmd.data[3:1])
        && mode_locked == $past(cmd.data[0]))
        else $error("mode command not applied");
    mode_hold_a: assert property (
        (mode_locked ##0 mode_cmd_s) |=> $stable(mode_bits))
        else $error("mode changed while locked");
    lock_stays_a: assert property (mode_locked |=> mode_locked)
        else $error("lock released");
    reply_hold_a: assert property (
        !cmd.valid [*2] |=> $stable(reply_byte))
        else $error("reply changed without command");
endmodule
bind pdil_top pdil_top_properties i_props (.clock(clock), .rst_n(rst_n),
    .enable_first(enable_first), .enable_second(enable_second),
    .phase_cmd(phase_cmd), .fault_trip(fault_trip),
    .fault_event(fault_event), .cmd(cmd), .reply_byte(reply_byte),
    .gate(gate), .standby_state(standby_state), .shutdown(shutdown),
    .irq_out(irq_out), .mode_bits(mode_bits), .mode_locked(mode_locked));

// *** dv/pdil_host.sv ***
/*
 * pdil_host: host model driving enables, phase pins and command bytes.
 * Assumes the bench calls its tasks; all changes land 2 ns after an edge.
 */
`timescale 1ns/1ps
module pdil_host
    import pdil_pkg::*;
(
    // clock
    input wire logic clock,
    // toward the device
    output logic enable_first,
    output logic enable_second,
    output pdil_phase_cmd_t phase_cmd,
    output pdil_cmd_t cmd
);
    initial begin
        enable_first = 1'b0;
        enable_second = 1'b0;
        phase_cmd = '{low_cmd: 3'h0, high_cmd_n: 3'h7};
        cmd = '0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    // data is inverted once invalid so a stale byte is never read as good
    task automatic send(input logic [7:0] b);
        tick(1);
        cmd = '{valid: 1'b1, data: b};
        tick(1);
        cmd = '{valid: 1'b0, data: ~b};
        tick(2);
    endtask
    // leaves margin past 280 ns plus synchroniser delay
    task automatic enable(input logic b);
        enable_first = b;
        enable_second = b;
        tick(PDIL_ENABLE_CYC + 8);
    endtask
    task automatic pins(input logic [2:0] lo, input logic [2:0] hi_n,
                        input int n);
        phase_cmd = '{low_cmd: lo, high_cmd_n: hi_n};
        tick(n);
    endtask
endmodule

// *** dv/pdil_top_tb.sv ***
/*
 * pdil_top_tb: directed bench for pdil_top through the host model.
 * Assumes the checker is bound to pdil_top; 40 MHz clock.
 */
`timescale 1ns/1ps
module pdil_top_tb
    import pdil_pkg::*;
();
    logic clock, rst_n, enable_first, enable_second, fault_trip;
    logic standby_state, shutdown, irq_out, mode_locked;
    logic [PDIL_IRQ_W-1:0] fault_event;
    logic [7:0] reply_byte;
    logic [PDIL_MODE_W-1:0] mode_bits;
    pdil_phase_cmd_t phase_cmd;
    pdil_cmd_t cmd;
    pdil_gate_t gate;
    int err_count = 0;
    int n_compared = 0;
    // no dead time in the design, so the high hold is recovery plus margin
    localparam int HOLD = PDIL_RECOV_CYC + 4;

    pdil_host i_host (.clock(clock), .enable_first(enable_first),
        .enable_second(enable_second), .phase_cmd(phase_cmd), .cmd(cmd));
    pdil_top i_dut (.clock(clock), .rst_n(rst_n),
        .enable_first(enable_first), .enable_second(enable_second),
        .phase_cmd(phase_cmd), .fault_trip(fault_trip),
        .fault_event(fault_event), .cmd(cmd), .reply_byte(reply_byte),
        .gate(gate), .standby_state(standby_state), .shutdown(shutdown),
        .irq_out(irq_out), .mode_bits(mode_bits), .mode_locked(mode_locked));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic fire(input logic [7:0] e);
        fault_event = e;
        i_host.tick(1);
        fault_event = '0;
        i_host.tick(3);
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        i_host.tick(4000);
        err_count++;
        conclude();
    end
    initial begin
        rst_n = 1'b0;
        fault_trip = 1'b0;
        fault_event = '0;
        i_host.tick(2);
        rst_n = 1'b1;
        i_host.tick(1);
        chk({2'h0, gate}, 8'h00);
        chk({6'h0, standby_state, shutdown}, 8'h03);
        chk({7'h0, irq_out}, 8'h00);
        chk(reply_byte, 8'h00);
        $display("test reset done");
        fire(8'h01);
        chk({7'h0, irq_out}, 8'h01);
        i_host.send(8'h00);
        i_host.send(8'h01);
        chk(reply_byte, 8'h11);
        i_host.send(8'h60);
        chk(reply_byte, 8'h01);
        chk({7'h0, irq_out}, 8'h00);
        i_host.send(8'h21);
        fire(8'h01);
        chk({7'h0, irq_out}, 8'h00);
        i_host.send(8'h3f);
        fire(8'h80);
        chk({7'h0, irq_out}, 8'h00);
        i_host.send(8'h20);
        chk({7'h0, irq_out}, 8'h01);
        i_host.send(8'h30);
        i_host.send(8'h60);
        i_host.send(8'h61);
        chk({7'h0, irq_out}, 8'h00);
        fire(8'h7e);
        chk({7'h0, irq_out}, 8'h01);
        i_host.send(8'h01);
        i_host.send(8'h60);
        chk(reply_byte, 8'h7e);
        chk({7'h0, irq_out}, 8'h01);
        i_host.send(8'h61);
        chk({7'h0, irq_out}, 8'h00);
        $display("test interrupt done");
        i_host.send(8'h47);
        chk({4'h0, mode_bits, mode_locked}, 8'h07);
        i_host.send(8'h42);
        chk({4'h0, mode_bits, mode_locked}, 8'h07);
        i_host.send(8'h02);
        i_host.send(8'h00);
        chk(reply_byte, 8'h07);
        $display("test mode done");
        i_host.enable(1'b1);
        chk({6'h0, standby_state, shutdown}, 8'h00);
        i_host.pins(3'h7, 3'h7, HOLD);
        chk({2'h0, gate}, 8'h07);
        i_host.pins(3'h0, 3'h7, 4);
        i_host.pins(3'h0, 3'h0, HOLD);
        chk({2'h0, gate}, 8'h38);
        i_host.pins(3'h0, 3'h7, 6);
        chk({2'h0, gate}, 8'h00);
        i_host.pins(3'h4, 3'h6, 6);
        chk({2'h0, gate}, 8'h0c);
        i_host.pins(3'h0, 3'h7, 6);
        $display("test init done");
        fault_trip = 1'b1;
        i_host.tick(1);
        fault_trip = 1'b0;
        i_host.tick(4);
        chk({7'h0, shutdown}, 8'h01);
        chk({2'h0, gate}, 8'h00);
        i_host.send(8'h00);
        i_host.send(8'h60);
        chk(reply_byte, 8'h20);
        i_host.send(8'h61);
        i_host.tick(PDIL_ENABLE_CYC + 8);
        i_host.pins(3'h0, 3'h6, 6);
        i_host.pins(3'h0, 3'h7, 6);
        i_host.pins(3'h7, 3'h7, HOLD);
        i_host.pins(3'h0, 3'h7, 4);
        i_host.pins(3'h0, 3'h0, HOLD);
        chk({2'h0, gate}, 8'h30);
        i_host.pins(3'h0, 3'h7, 6);
        $display("test fault done");
        i_host.enable(1'b0);
        chk({6'h0, standby_state, shutdown}, 8'h03);
        chk({2'h0, gate}, 8'h00);
        $display("test standby done");
        conclude();
    end
endmodule
